// ---- design/cmd_slice_consts.svh ----
/*
 * Constants for the command-decoding slice: opcodes, frame layout, status codes,
 * register offsets and field positions.
 * Assumes it is included by bare name wherever these numbers are needed.
 */
`ifndef CMD_SLICE_CONSTS_SVH
`define CMD_SLICE_CONSTS_SVH

`define OP_ACCU_TO_AXIS    8'h22
`define OP_ACCU_TO_GLOBAL  8'h23
`define OP_FLAG_CLEAR      8'h24
`define OP_IRQ_UNMASK      8'h19
`define OP_IRQ_MASK_OFF    8'h1A
`define OP_HANDLER_BIND    8'h25
`define OP_IRQ_RETURN      8'h26

`define IRQ_ALL_NUM        8'hFF
`define STATUS_OK          8'h64
`define STATUS_BAD_CSUM    8'h01
`define STATUS_BAD_CMD     8'h02
`define STATUS_BAD_TYPE    8'h03
`define STATUS_BAD_VALUE   8'h04
`define STATUS_NOT_STORED  8'h06

`define FRAME_LAST         4'h8
`define FRAME_FIRST        4'h0
`define BANK_0             8'h00
`define BANK_2             8'h02
`define BANK_3             8'h03

`define FLAG_SEL_ALL       8'h00
`define FLAG_SEL_MAX       8'h05
`define NUM_FLAGS          5
`define NUM_IRQ            16
`define IRQ_IDX_W          4

`define REG_IRQ_STATUS     4'h0
`define REG_IRQ_MASK       4'h1
`define REG_ERR_FLAGS      4'h2
`define REG_GLOBAL_EN      4'h3
`define REG_ACCU           4'h4
`define REG_PC             4'h5
`define EV_ACCEPT          0
`define EV_REJECT          1
`define EV_IRQ_TAKEN       2
`define NUM_EV             3

`endif

// ---- design/cmd_slice_pkg.sv ----
/*
 * Types for the command-decoding slice.
 * Assumes the constants header is in the include path.
 */
`include "cmd_slice_consts.svh"
package cmd_slice_pkg;
    typedef struct packed {
        logic [7:0]  target;
        logic [7:0]  opcode;
        logic [7:0]  ctype;
        logic [7:0]  bank;
        logic [31:0] value;
        logic [7:0]  csum;
    } cmd_frame_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  status;
        logic [7:0]  opcode;
        logic [31:0] value;
    } cmd_reply_t;

    typedef struct packed {
        logic        valid;
        logic        global_sel;
        logic [7:0]  index;
        logic [7:0]  bank;
        logic [31:0] data;
    } param_write_t;

    typedef struct packed {
        logic [31:0] accu;
        logic [31:0] xreg;
        logic [7:0]  flags;
        logic [31:0] pc;
    } cpu_ctx_t;
endpackage

// ---- design/cmd_slice.sv ----
/*
 * Command-decoding slice: frame assembly, checksum, accumulator stores,
 * error-flag clearing, interrupt enables, handler vectors, interrupt entry/return,
 * status replies and a small register port with interrupt status/mask.
 * Assumes bytes arrive synchronously on clk_sys, one per strobe, and that the
 * program engine and parameter tables sit outside.
 */
`timescale 1ns/1ns
`include "cmd_slice_consts.svh"

// Notes on behaviour
// RULE_01 - the axis-parameter store opcode writes the accumulator to the typed parameter of the given motor.
// RULE_02 - the global-parameter store opcode writes the accumulator to the typed parameter in bank 0, 2 or 3, ignoring value bytes.
// RULE_03 - every handled command answers with status 100 and a meaningless value.
// RULE_04 - the flag-clear opcode clears only the flags chosen by the type byte.
// RULE_05 - type 0 clears all flags, 1 timeout, 2 external alarm, 3 deviation, 4 position error, 5 shutdown.
// RULE_06 - the unmask opcode sets the enable of the interrupt named by the type byte.
// RULE_07 - unmask with number 255 sets the global interrupt enable instead.
// RULE_08 - the mask-off opcode clears the enable of the interrupt named by the type byte.
// RULE_09 - mask-off with number 255 clears the global enable, blocking all handling.
// RULE_10 - the vector command records the handler entry address for the interrupt number.
// RULE_11 - a later vector command for the same number overwrites the stored address.
// RULE_12 - the vector command runs only from the stored program, not from the host.
// RULE_13 - a frame is target, opcode, type, motor or bank, four value bytes high first, checksum.
// RULE_14 - the vector command is opcode 37 with number in type and address in value.
// RULE_15 - interrupt return restores accumulator, X register, flags and program counter.
// RULE_16 - the checksum is the byte sum of the first eight bytes and a mismatch rejects the frame.
// RULE_17 - an interrupt is taken only with source and global enable set, saving context and jumping.
module cmd_slice (
    input  wire logic                      clk_sys,
    input  wire logic                      sys_rst,
    input  wire logic                      byte_valid,
    input  wire logic [7:0]                byte_data,
    input  wire logic                      from_program,
    input  wire logic [31:0]               accu_in,
    input  wire cmd_slice_pkg::cpu_ctx_t   ctx_in,
    input  wire logic [4:0]                err_set,
    input  wire logic [15:0]               irq_req,
    input  wire logic [3:0]                reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output cmd_slice_pkg::cmd_reply_t      reply,
    output cmd_slice_pkg::param_write_t    param_wr,
    output cmd_slice_pkg::cpu_ctx_t        ctx_restore,
    output logic                           ctx_restore_valid,
    output cmd_slice_pkg::cpu_ctx_t        ctx_saved,
    output logic                           irq_jump,
    output logic [31:0]                    irq_jump_addr,
    output logic [4:0]                     err_flags,
    output logic [31:0]                    reg_rdata,
    output logic                           irq_out
);
    import cmd_slice_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_EXEC   = 3'b010,
        ST_INTR   = 3'b100
    } state_t;

    state_t              state;
    cmd_frame_t          frame;
    logic [3:0]          byte_cnt;
    logic [7:0]          csum_acc;
    logic                frame_src_prog;
    logic [15:0]         src_en;
    logic                global_en;
    logic                in_handler;
    logic [31:0]         vector [`NUM_IRQ];
    logic [`NUM_IRQ-1:0] vector_set;
    logic [`NUM_EV-1:0]  ev_status;
    logic [`NUM_EV-1:0]  ev_mask;
    logic [`NUM_EV-1:0]  ev_pulse;
    logic [`IRQ_IDX_W-1:0] pick;
    logic                pick_ok;
    logic [4:0]          clr_mask;
    logic                csum_ok;

    assign csum_ok = (csum_acc == frame.csum); // RULE_16

    // frame assembly; checksum tracked as bytes arrive
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            frame          <= '0;
            byte_cnt       <= `FRAME_FIRST;
            csum_acc       <= 8'h00;
            frame_src_prog <= 1'b0;
        end else if (state != ST_IDLE) begin
            byte_cnt <= `FRAME_FIRST;
        end else if (byte_valid) begin
            frame <= {frame[63:0], byte_data}; // RULE_13
            if (byte_cnt == `FRAME_FIRST) begin
                csum_acc       <= byte_data;
                frame_src_prog <= from_program;
            end else if (byte_cnt != `FRAME_LAST) begin
                csum_acc <= csum_acc + byte_data; // RULE_16
            end
            byte_cnt <= (byte_cnt == `FRAME_LAST) ? `FRAME_FIRST : byte_cnt + 4'h1;
        end
    end

    // highest-priority pending enabled source
    always_comb begin
        pick    = '0;
        pick_ok = 1'b0;
        for (int i = `NUM_IRQ - 1; i >= 0; i--) begin
            if (irq_req[i] && src_en[i] && vector_set[i]) begin
                pick    = i[`IRQ_IDX_W-1:0];
                pick_ok = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (byte_valid && byte_cnt == `FRAME_LAST) begin
                        state <= ST_EXEC;
                    end else if (pick_ok && global_en && !in_handler) begin
                        state <= ST_INTR; // RULE_17
                    end
                end
                ST_EXEC: state <= ST_IDLE;
                ST_INTR: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // flag-clear selection
    always_comb begin
        clr_mask = 5'h00;
        if (frame.ctype == `FLAG_SEL_ALL) begin
            clr_mask = 5'h1F; // RULE_05
        end else if (frame.ctype <= `FLAG_SEL_MAX) begin
            clr_mask[frame.ctype[2:0] - 3'h1] = 1'b1; // RULE_05
        end
    end

    logic exec_ok;
    assign exec_ok = (state == ST_EXEC) && csum_ok;

    // command execution and reply
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reply    <= '0;
            param_wr <= '0;
            ev_pulse <= '0;
        end else begin
            reply.valid    <= 1'b0;
            param_wr.valid <= 1'b0;
            ev_pulse       <= '0;
            if (state == ST_EXEC) begin
                reply.valid  <= 1'b1;
                reply.opcode <= frame.opcode;
                reply.value  <= 32'h0000_0000;
                reply.status <= `STATUS_OK; // RULE_03
                ev_pulse[`EV_ACCEPT] <= csum_ok;
                ev_pulse[`EV_REJECT] <= !csum_ok;
                if (!csum_ok) begin
                    reply.status <= `STATUS_BAD_CSUM; // RULE_16
                end else begin
                    case (frame.opcode)
                        `OP_ACCU_TO_AXIS: begin
                            param_wr <= '{1'b1, 1'b0, frame.ctype, frame.bank, accu_in}; // RULE_01
                        end
                        `OP_ACCU_TO_GLOBAL: begin
                            if (frame.bank == `BANK_0 || frame.bank == `BANK_2
                                || frame.bank == `BANK_3) begin
                                param_wr <= '{1'b1, 1'b1, frame.ctype, frame.bank, accu_in}; // RULE_02
                            end else begin
                                reply.status <= `STATUS_BAD_VALUE;
                            end
                        end
                        `OP_FLAG_CLEAR: begin
                            if (frame.ctype > `FLAG_SEL_MAX) begin
                                reply.status <= `STATUS_BAD_TYPE;
                            end
                        end
                        `OP_HANDLER_BIND: begin
                            if (!frame_src_prog) begin
                                reply.status <= `STATUS_NOT_STORED; // RULE_12
                            end
                        end
                        `OP_IRQ_UNMASK, `OP_IRQ_MASK_OFF, `OP_IRQ_RETURN: begin
                        end
                        default: reply.status <= `STATUS_BAD_CMD;
                    endcase
                end
            end
        end
    end

    // error flags: hardware set wins over a clear in the same cycle
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            err_flags <= 5'h00;
        end else if (exec_ok && frame.opcode == `OP_FLAG_CLEAR) begin
            err_flags <= (err_flags & ~clr_mask) | err_set; // RULE_04
        end else begin
            err_flags <= err_flags | err_set;
        end
    end

    // interrupt enables
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            src_en    <= 16'h0000;
            global_en <= 1'b0;
        end else if (exec_ok && frame.opcode == `OP_IRQ_UNMASK) begin
            if (frame.ctype == `IRQ_ALL_NUM) begin
                global_en <= 1'b1; // RULE_07
            end else if (frame.ctype < `NUM_IRQ) begin
                src_en[frame.ctype[`IRQ_IDX_W-1:0]] <= 1'b1; // RULE_06
            end
        end else if (exec_ok && frame.opcode == `OP_IRQ_MASK_OFF) begin
            if (frame.ctype == `IRQ_ALL_NUM) begin
                global_en <= 1'b0; // RULE_09
            end else if (frame.ctype < `NUM_IRQ) begin
                src_en[frame.ctype[`IRQ_IDX_W-1:0]] <= 1'b0; // RULE_08
            end
        end
    end

    // handler vectors; table is cleared valid bits, words hold no reset
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            vector_set <= '0;
        end else if (exec_ok && frame.opcode == `OP_HANDLER_BIND && frame_src_prog
                     && frame.ctype < `NUM_IRQ) begin
            vector_set[frame.ctype[`IRQ_IDX_W-1:0]] <= 1'b1; // RULE_14
        end
    end

    always_ff @(posedge clk_sys) begin
        if (exec_ok && frame.opcode == `OP_HANDLER_BIND && frame_src_prog
            && frame.ctype < `NUM_IRQ) begin
            vector[frame.ctype[`IRQ_IDX_W-1:0]] <= frame.value; // RULE_10 RULE_11
        end
    end

    // interrupt entry and return
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctx_saved         <= '0;
            ctx_restore       <= '0;
            ctx_restore_valid <= 1'b0;
            irq_jump          <= 1'b0;
            irq_jump_addr     <= 32'h0000_0000;
            in_handler        <= 1'b0;
        end else begin
            irq_jump          <= 1'b0;
            ctx_restore_valid <= 1'b0;
            if (state == ST_INTR) begin
                ctx_saved     <= ctx_in; // RULE_17
                irq_jump      <= 1'b1;
                irq_jump_addr <= vector[pick];
                in_handler    <= 1'b1;
            end else if (exec_ok && frame.opcode == `OP_IRQ_RETURN && in_handler) begin
                ctx_restore       <= ctx_saved; // RULE_15
                ctx_restore_valid <= 1'b1;
                in_handler        <= 1'b0;
            end
        end
    end

    logic ev_pulse_irq;
    assign ev_pulse_irq = (state == ST_INTR);

    // sticky event status, write one to clear; a new event wins
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ev_status <= '0;
            ev_mask   <= '0;
        end else begin
            if (reg_wr && reg_addr == `REG_IRQ_MASK) begin
                ev_mask <= reg_wdata[`NUM_EV-1:0];
            end
            if (reg_wr && reg_addr == `REG_IRQ_STATUS) begin
                ev_status <= (ev_status & ~reg_wdata[`NUM_EV-1:0]) | ev_pulse
                             | {ev_pulse_irq, 2'b00};
            end else begin
                ev_status <= ev_status | ev_pulse | {ev_pulse_irq, 2'b00};
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |((ev_status | ev_pulse | {ev_pulse_irq, 2'b00}) & ev_mask);
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `REG_IRQ_STATUS: reg_rdata <= {29'h0, ev_status};
                `REG_IRQ_MASK:   reg_rdata <= {29'h0, ev_mask};
                `REG_ERR_FLAGS:  reg_rdata <= {27'h0, err_flags};
                `REG_GLOBAL_EN:  reg_rdata <= {15'h0, global_en, src_en};
                `REG_ACCU:       reg_rdata <= accu_in;
                `REG_PC:         reg_rdata <= irq_jump_addr;
                default:         reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    a_axis_store: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (exec_ok && frame.opcode == `OP_ACCU_TO_AXIS) |=>
        (param_wr.valid && !param_wr.global_sel && param_wr.data == $past(accu_in)))
        else $error("axis store missing"); // RULE_01
    a_global_bank: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (param_wr.valid && param_wr.global_sel) |->
        (param_wr.bank == `BANK_0 || param_wr.bank == `BANK_2 || param_wr.bank == `BANK_3))
        else $error("global store to bad bank"); // RULE_02
    a_reply_ok: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (exec_ok && frame.opcode == `OP_FLAG_CLEAR && frame.ctype <= `FLAG_SEL_MAX)
        |=> (reply.valid && reply.status == `STATUS_OK))
        else $error("reply status not ok"); // RULE_03
    a_clear_all: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (exec_ok && frame.opcode == `OP_FLAG_CLEAR && frame.ctype == `FLAG_SEL_ALL)
        |=> (err_flags == $past(err_set)))
        else $error("clear all left flags"); // RULE_05
    a_global_on: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (exec_ok && frame.opcode == `OP_IRQ_UNMASK && frame.ctype == `IRQ_ALL_NUM)
        |=> (global_en && $stable(src_en)))
        else $error("global enable not set"); // RULE_07
    a_global_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (exec_ok && frame.opcode == `OP_IRQ_MASK_OFF && frame.ctype == `IRQ_ALL_NUM)
        |=> !global_en)
        else $error("global enable not cleared"); // RULE_09
    a_bind_host: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (exec_ok && frame.opcode == `OP_HANDLER_BIND && !frame_src_prog)
        |=> (reply.status == `STATUS_NOT_STORED && $stable(vector_set)))
        else $error("host vector accepted"); // RULE_12
    a_bad_csum: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state == ST_EXEC && !csum_ok) |=> (reply.status == `STATUS_BAD_CSUM && !param_wr.valid))
        else $error("bad checksum accepted"); // RULE_16
    a_irq_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
        irq_jump |-> $past(global_en, 2))
        else $error("interrupt taken while disabled"); // RULE_17
    a_return_ctx: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ctx_restore_valid |-> (ctx_restore == ctx_saved && !in_handler))
        else $error("context not restored"); // RULE_15
endmodule // cmd_slice

// ---- tb/frame_host.sv ----
/*
 * Partner model: the host link or program engine that feeds command frames
 * into the slice, one byte per clock.
 * Assumes one clock shared with the slice; the bench calls send.
 */
`timescale 1ns/1ns
module frame_host (
    input  wire logic       clk_sys,
    output logic            byte_valid,
    output logic [7:0]      byte_data,
    output logic            from_program
);
    initial begin
        byte_valid   = 1'b0;
        byte_data    = 8'hA5;
        from_program = 1'b0;
    end

    // bad turns the checksum round so the frame must be refused
    task automatic send(input logic prog, input logic [7:0] op, input logic [7:0] ctype,
                        input logic [7:0] bank, input logic [31:0] value, input logic bad);
        logic [7:0] fr [0:8];
        logic [7:0] sum;
        fr = '{8'h01, op, ctype, bank, value[31:24], value[23:16], value[15:8], value[7:0],
               8'h00};
        sum = 8'h00;
        for (int i = 0; i < 8; i++) begin
            sum = sum + fr[i];
        end
        fr[8] = bad ? ~sum : sum;
        for (int i = 0; i < 9; i++) begin
            @(posedge clk_sys);
            byte_valid <= 1'b1;
            byte_data  <= fr[i];
            from_program <= prog;
        end
        @(posedge clk_sys);
        byte_valid <= 1'b0;
        // idle line must not keep showing the checksum
        byte_data  <= ~fr[8];
    endtask
endmodule // frame_host

// ---- tb/accu_store_flag_irq_cmds_test.sv ----
/*
 * Self-checking bench for the command slice: stores, flag clears, interrupt
 * enables, vectors, entry and return, event status and register port.
 * Assumes the slice package and constants header are compiled first.
 */
`timescale 1ns/1ns
`include "cmd_slice_consts.svh"
module accu_store_flag_irq_cmds_test;
    import cmd_slice_pkg::*;
    logic         clk_sys, sys_rst, byte_valid, from_program, reg_wr, reg_rd;
    logic         ctx_restore_valid, irq_jump, irq_out, seen;
    logic [7:0]   byte_data;
    logic [31:0]  accu_in, reg_wdata, reg_rdata, irq_jump_addr, d;
    logic [4:0]   err_set, err_flags;
    logic [15:0]  irq_req;
    logic [3:0]   reg_addr;
    cpu_ctx_t     ctx_in, ctx_restore, ctx_saved, ctx_first;
    cmd_reply_t   reply;
    param_write_t param_wr;
    int           errors, check_count, cycles;
    logic [7:0]   banks [3] = '{`BANK_0, `BANK_2, `BANK_3};

    frame_host host (.clk_sys(clk_sys), .byte_valid(byte_valid), .byte_data(byte_data),
                     .from_program(from_program));
    cmd_slice uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .byte_valid(byte_valid),
        .byte_data(byte_data), .from_program(from_program), .accu_in(accu_in),
        .ctx_in(ctx_in), .err_set(err_set), .irq_req(irq_req), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reply(reply),
        .param_wr(param_wr), .ctx_restore(ctx_restore),
        .ctx_restore_valid(ctx_restore_valid), .ctx_saved(ctx_saved), .irq_jump(irq_jump),
        .irq_jump_addr(irq_jump_addr), .err_flags(err_flags), .reg_rdata(reg_rdata),
        .irq_out(irq_out));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ceiling well above the few hundred cycles the tests take
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("unexpected at %0t: run hung", $time);
            test_done();
        end
    end

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_ctx(input cpu_ctx_t got, input cpu_ctx_t exp, input string msg);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s context differs", $time, msg);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    // reply pulse stands only in the cycle after the exec cycle
    task automatic cmd(input logic prog, input logic [7:0] op, input logic [7:0] ctype,
                       input logic [7:0] bank, input logic [31:0] v, input logic bad,
                       input logic [7:0] st);
        host.send(prog, op, ctype, bank, v, bad);
        @(posedge clk_sys);
        #1;
        chk_val(reply.valid, 1'b1, "reply pulse");
        chk_val(reply.status, st, "reply status");
        chk_val(reply.opcode, op, "reply opcode");
    endtask

    task automatic wait_jump(input int n);
        seen = 1'b0;
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            if (irq_jump === 1'b1) begin
                seen = 1'b1;
                break;
            end
        end
    endtask

    task automatic t_store;
        @(posedge clk_sys);
        accu_in <= 32'hDEAD_0042;
        cmd(1'b0, `OP_ACCU_TO_AXIS, 8'h05, 8'h01, 32'h0, 1'b0, `STATUS_OK);
        chk_val(param_wr.valid, 1'b1, "axis store");
        chk_val({param_wr.global_sel, param_wr.index, param_wr.bank}, 17'h00501, "axis sel");
        chk_val(param_wr.data, 32'hDEAD_0042, "axis data");
        foreach (banks[i]) begin
            cmd(1'b1, `OP_ACCU_TO_GLOBAL, 8'h2A, banks[i], 32'h1234_5678, 1'b0, `STATUS_OK);
            chk_val({param_wr.valid, param_wr.global_sel, param_wr.bank},
                    {2'b11, banks[i]}, "global sel");
            chk_val(param_wr.data, 32'hDEAD_0042, "global data");
        end
        cmd(1'b0, `OP_ACCU_TO_GLOBAL, 8'h2A, 8'h01, 32'h0, 1'b0, `STATUS_BAD_VALUE);
        chk_val(param_wr.valid, 1'b0, "bank 1 stored");
        $display("test store done");
    endtask

    task automatic set_all_flags;
        @(posedge clk_sys);
        err_set <= 5'h1F;
        @(posedge clk_sys);
        err_set <= 5'h00;
    endtask

    task automatic t_flags;
        for (int k = 1; k <= 5; k++) begin
            set_all_flags();
            cmd(1'b0, `OP_FLAG_CLEAR, k[7:0], 8'h07, 32'hFFFF_FFFF, 1'b0, `STATUS_OK);
            chk_val(err_flags, 5'h1F & ~(5'h01 << (k - 1)), "one flag");
        end
        set_all_flags();
        cmd(1'b0, `OP_FLAG_CLEAR, 8'h06, 8'h00, 32'h0, 1'b0, `STATUS_BAD_TYPE);
        chk_val(err_flags, 5'h1F, "type 6");
        cmd(1'b0, `OP_FLAG_CLEAR, `FLAG_SEL_ALL, 8'h00, 32'h0, 1'b1, `STATUS_BAD_CSUM);
        chk_val(err_flags, 5'h1F, "bad checksum");
        cmd(1'b0, `OP_FLAG_CLEAR, `FLAG_SEL_ALL, 8'h00, 32'h0, 1'b0, `STATUS_OK);
        chk_val(err_flags, 5'h00, "all flags");
        $display("test flags done");
    endtask

    task automatic t_irq;
        ctx_first = '{32'h11, 32'h22, 8'h33, 32'h44};
        @(posedge clk_sys);
        ctx_in <= ctx_first;
        cmd(1'b0, `OP_HANDLER_BIND, 8'h03, 8'h00, 32'h50, 1'b0, `STATUS_NOT_STORED);
        cmd(1'b1, `OP_HANDLER_BIND, 8'h03, 8'h00, 32'h50, 1'b0, `STATUS_OK);
        cmd(1'b1, `OP_HANDLER_BIND, 8'h03, 8'h00, 32'h70, 1'b0, `STATUS_OK);
        cmd(1'b1, `OP_IRQ_UNMASK, 8'h03, 8'h05, 32'hFFFF, 1'b0, `STATUS_OK);
        reg_read(`REG_GLOBAL_EN, d);
        chk_val(d, 32'h0000_0008, "source on");
        irq_req <= 16'h0008;
        wait_jump(8);
        chk_val(seen, 1'b0, "taken without global");
        cmd(1'b1, `OP_IRQ_UNMASK, `IRQ_ALL_NUM, 8'h00, 32'h0, 1'b0, `STATUS_OK);
        wait_jump(8);
        chk_val(seen, 1'b1, "taken");
        chk_val(irq_jump_addr, 32'h70, "handler address");
        chk_ctx(ctx_saved, ctx_first, "saved");
        reg_read(`REG_GLOBAL_EN, d);
        chk_val(d, 32'h0001_0008, "global on");
        irq_req <= 16'h0000;
        ctx_in  <= '{32'h99, 32'h88, 8'h77, 32'h66};
        cmd(1'b1, `OP_IRQ_RETURN, `IRQ_ALL_NUM, 8'h00, 32'h0, 1'b0, `STATUS_OK);
        chk_val(ctx_restore_valid, 1'b1, "restore pulse");
        chk_ctx(ctx_restore, ctx_first, "restored");
        cmd(1'b1, `OP_IRQ_MASK_OFF, `IRQ_ALL_NUM, 8'h00, 32'h0, 1'b0, `STATUS_OK);
        reg_read(`REG_GLOBAL_EN, d);
        chk_val(d, 32'h0000_0008, "global off");
        irq_req <= 16'h0008;
        wait_jump(8);
        chk_val(seen, 1'b0, "taken while off");
        cmd(1'b1, `OP_IRQ_MASK_OFF, 8'h03, 8'h05, 32'h1, 1'b0, `STATUS_OK);
        cmd(1'b1, `OP_IRQ_UNMASK, `IRQ_ALL_NUM, 8'h00, 32'h0, 1'b0, `STATUS_OK);
        wait_jump(8);
        chk_val(seen, 1'b0, "masked source");
        reg_read(`REG_GLOBAL_EN, d);
        chk_val(d, 32'h0001_0000, "source off");
        irq_req <= 16'h0000;
        $display("test irq done");
    endtask

    task automatic t_regs;
        reg_read(`REG_IRQ_STATUS, d);
        chk_val(d, 32'h7, "events");
        reg_write(`REG_IRQ_STATUS, 32'h7);
        reg_read(`REG_IRQ_STATUS, d);
        chk_val(d, 32'h0, "events cleared");
        reg_write(`REG_IRQ_MASK, 32'h1);
        reg_read(`REG_IRQ_MASK, d);
        chk_val(d, 32'h1, "mask");
        cmd(1'b0, `OP_FLAG_CLEAR, 8'h01, 8'h00, 32'h0, 1'b0, `STATUS_OK);
        repeat (2) @(posedge clk_sys);
        #1;
        chk_val(irq_out, 1'b1, "irq raised");
        reg_write(`REG_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge clk_sys);
        #1;
        chk_val(irq_out, 1'b0, "irq cleared");
        reg_read(`REG_ACCU, d);
        chk_val(d, 32'hDEAD_0042, "accu read");
        reg_read(4'hF, d);
        chk_val(d, 32'h0, "unmapped");
        $display("test regs done");
    endtask

    initial begin
        sys_rst   = 1'b1;
        accu_in   = 32'h0;
        ctx_in    = '0;
        err_set   = 5'h00;
        irq_req   = 16'h0000;
        reg_addr  = 4'h0;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_store();
        t_flags();
        t_irq();
        t_regs();
        test_done();
    end
endmodule // accu_store_flag_irq_cmds_test
